//--- src/pcf_clock_fanout.v
// Clock fan-out with per-bank gating, duty restore, bypass and lock tracking
`timescale 1ns/10ps
`default_nettype none
`include "pcf_defs.vh"

module pcf_clock_fanout #(
  parameter integer STAB_CYCLES = (`PCF_STAB_TIME_US * `PCF_SYS_CLK_KHZ) / 1000
) (
  // Clock and reset
  input  wire                      ref_clk_i,
  input  wire                      reset_n_i,
  // Reference and loop
  input  wire                      reference_in_i,
  input  wire                      feedback_in_i,
  output wire                      feedback_out_o,
  output wire                      lock_valid_o,
  // Control
  input  wire                      bank_a_enable_i,
  input  wire                      bank_b_enable_i,
  input  wire                      analog_supply_strap_i,
  // Clock outputs
  output wire [`PCF_BANK_A_W-1:0]  bank_a_outputs_o,
  output wire [`PCF_BANK_B_W-1:0]  bank_b_outputs_o
);

  // Lock tracker states
  localparam ST_ACQ  = 1'h0;
  localparam ST_LOCK = 1'h1;

  // Input edge detection
  reg                      ref_prev_r;
  reg                      fb_prev_r;
  // Period measurement
  reg  [`PCF_CNT_W-1:0]    cnt_r;
  reg  [`PCF_CNT_W-1:0]    cnt_nxt;
  reg  [`PCF_CNT_W-1:0]    period_r;
  reg  [`PCF_CNT_W-1:0]    period_nxt;
  reg                      period_ok_r;
  reg                      period_ok_nxt;
  // Duty restore and output stage
  reg                      gen_r;
  reg                      gen_nxt;
  reg                      fb_out_r;
  reg  [`PCF_BANK_A_W-1:0] bank_a_r;
  reg  [`PCF_BANK_A_W-1:0] bank_a_nxt;
  reg  [`PCF_BANK_B_W-1:0] bank_b_r;
  reg  [`PCF_BANK_B_W-1:0] bank_b_nxt;
  // Lock tracking
  reg                      state_r;
  reg                      state_nxt;
  reg  [`PCF_STAB_W-1:0]   stab_r;
  reg  [`PCF_STAB_W-1:0]   stab_nxt;
  reg                      fb_seen_r;
  reg                      fb_seen_nxt;
  // Combinational helpers
  wire                     ref_rise;
  wire                     fb_rise;
  wire                     bypass;
  wire                     src;
  wire                     period_changed;
  wire                     ref_lost;
  wire                     fb_late;
  wire                     fb_missing;
  wire                     disturb;
  wire [`PCF_STAB_W-1:0]   stab_last;

  // Wrapping increment shared by the period counter and the period capture
  function [`PCF_CNT_W-1:0] cnt_plus_one;
    input [`PCF_CNT_W-1:0] value;
    begin
      cnt_plus_one = value + 8'h01;
    end
  endfunction

  // Gating shared by both banks: a disabled bank is parked low, never left floating
  function gated_bit;
    input enable;
    input clk_bit;
    begin
      gated_bit = enable & clk_bit;
    end
  endfunction

  // Edges are found against the previous sample; both pins idle low after reset
  assign ref_rise = reference_in_i & ~ref_prev_r;
  assign fb_rise  = feedback_in_i & ~fb_prev_r;

  // Strap low selects bypass
  assign bypass   = ~analog_supply_strap_i;
  // Bypass takes the raw reference, so its duty is not restored
  assign src      = bypass ? reference_in_i : gen_r;

  // Last count of the stabilization interval before lock is declared
  assign stab_last = STAB_CYCLES[`PCF_STAB_W-1:0] - 20'h00001;

  // Period measurement between reference rising edges
  always @* begin
    cnt_nxt       = cnt_r;
    period_nxt    = period_r;
    period_ok_nxt = period_ok_r;
    if (ref_rise) begin
      cnt_nxt       = {`PCF_CNT_W{1'h0}};
      period_nxt    = cnt_plus_one(cnt_r);
      // A rise after a lost reference measures nothing useful
      period_ok_nxt = (cnt_r != `PCF_CNT_MAX);
    end else if (cnt_r != `PCF_CNT_MAX) begin
      cnt_nxt = cnt_plus_one(cnt_r);
    end
  end

  // High for the first half of the measured period, rising on the reference edge;
  // odd periods lose the extra half cycle because only whole sample cycles exist
  always @* begin
    gen_nxt = 1'h0;
    if (period_nxt > 8'h01) begin
      gen_nxt = (cnt_nxt < {1'h0, period_nxt[`PCF_CNT_W-1:1]});
    end
  end

  // Bank gating; the feedback path ignores both enables
  always @* begin
    bank_a_nxt = {`PCF_BANK_A_W{gated_bit(bank_a_enable_i, src)}};
    bank_b_nxt = {`PCF_BANK_B_W{gated_bit(bank_b_enable_i, src)}};
  end

  // Disturbance sources; any one of them restarts the stabilization interval
  assign period_changed = ref_rise && (period_nxt != period_r);
  assign ref_lost       = (cnt_r == `PCF_CNT_MAX);
  assign fb_late        = fb_rise && (cnt_r > `PCF_FB_WIN);
  assign fb_missing     = ref_rise && period_ok_r && !fb_seen_r;
  // Bypass holds the tracker out of lock since the loop is not in the path
  assign disturb        = period_changed | ref_lost | fb_late | fb_missing | bypass;

  // Feedback seen in the current reference period; a coincident rise counts for the new period
  always @* begin
    fb_seen_nxt = fb_seen_r;
    if (fb_rise) begin
      fb_seen_nxt = 1'h1;
    end else if (ref_rise) begin
      fb_seen_nxt = 1'h0;
    end
  end

  // Lock tracking
  always @* begin
    state_nxt = state_r;
    stab_nxt  = stab_r;
    case (state_r)
      ST_ACQ: begin
        if (disturb) begin
          stab_nxt = {`PCF_STAB_W{1'h0}};
        end else if (stab_r >= stab_last) begin
          state_nxt = ST_LOCK;
        end else begin
          stab_nxt = stab_r + 20'h00001;
        end
      end
      ST_LOCK: begin
        if (disturb) begin
          state_nxt = ST_ACQ;
          stab_nxt  = {`PCF_STAB_W{1'h0}};
        end
      end
      default: begin
        state_nxt = ST_ACQ;
        stab_nxt  = {`PCF_STAB_W{1'h0}};
      end
    endcase
  end

  // Input samples and measurement registers
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_prev_r  <= 1'h0;
      fb_prev_r   <= 1'h0;
      // Start as if the reference were lost, so no lock before two clean periods
      cnt_r       <= `PCF_CNT_MAX;
      period_r    <= {`PCF_CNT_W{1'h0}};
      period_ok_r <= 1'h0;
      fb_seen_r   <= 1'h0;
    end else begin
      ref_prev_r  <= reference_in_i;
      fb_prev_r   <= feedback_in_i;
      cnt_r       <= cnt_nxt;
      period_r    <= period_nxt;
      period_ok_r <= period_ok_nxt;
      fb_seen_r   <= fb_seen_nxt;
    end
  end

  // Lock tracker registers
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_ACQ;
      stab_r  <= {`PCF_STAB_W{1'h0}};
    end else begin
      state_r <= state_nxt;
      stab_r  <= stab_nxt;
    end
  end

  // Clock generator and output stage
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gen_r    <= 1'h0;
      fb_out_r <= 1'h0;
      bank_a_r <= {`PCF_BANK_A_W{1'h0}};
      bank_b_r <= {`PCF_BANK_B_W{1'h0}};
    end else begin
      gen_r    <= gen_nxt;
      fb_out_r <= src;
      bank_a_r <= bank_a_nxt;
      bank_b_r <= bank_b_nxt;
    end
  end

  // Feedback output leaves on the same register stage as the banks so that all edges line up
  assign feedback_out_o   = fb_out_r;
  assign bank_a_outputs_o = bank_a_r;
  assign bank_b_outputs_o = bank_b_r;
  assign lock_valid_o     = state_r;

endmodule
`default_nettype wire

//--- src/pcf_defs.vh
// Constants for the clock fan-out and gating block
`ifndef PCF_DEFS_VH
`define PCF_DEFS_VH

`define PCF_BANK_A_W      5
`define PCF_BANK_B_W      4
`define PCF_CNT_W         8
`define PCF_CNT_MAX       8'hff
`define PCF_SYS_CLK_KHZ   50000
`define PCF_STAB_TIME_US  1000
`define PCF_STAB_W        20
`define PCF_FB_WIN        8'h03

`endif

//--- tb/pcf_checker.sv
// Port checker for the clock fan-out block
`timescale 1ns/10ps
`default_nettype none
`include "pcf_defs.vh"
module pcf_checker #(
  parameter integer STAB_CYCLES = 20
) (
  // Clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     reset_n_i,
  // Reference and loop
  input wire logic                     reference_in_i,
  input wire logic                     feedback_in_i,
  input wire logic                     feedback_out_o,
  input wire logic                     lock_valid_o,
  // Control
  input wire logic                     bank_a_enable_i,
  input wire logic                     bank_b_enable_i,
  input wire logic                     analog_supply_strap_i,
  // Clock outputs
  input wire logic [`PCF_BANK_A_W-1:0] bank_a_outputs_o,
  input wire logic [`PCF_BANK_B_W-1:0] bank_b_outputs_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Cycles since reset or bypass; lock cannot come sooner
  logic [15:0] run_r;
  // Consecutive cycles with lock low; every fresh lock needs a full interval of them
  logic [15:0] low_r;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_r <= 16'h0;
    end else if (!analog_supply_strap_i) begin
      run_r <= 16'h0;
    end else if (run_r != 16'hffff) begin
      run_r <= run_r + 16'h1;
    end
  end
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_r <= 16'h0;
    end else if (lock_valid_o) begin
      low_r <= 16'h0;
    end else if (low_r != 16'hffff) begin
      low_r <= low_r + 16'h1;
    end
  end
  property p_aoff; !bank_a_enable_i |=> bank_a_outputs_o == '0; endproperty
  a_aoff: assert property (p_aoff) else $error("bank a not low");
  property p_boff; !bank_b_enable_i |=> bank_b_outputs_o == '0; endproperty
  a_boff: assert property (p_boff) else $error("bank b not low");
  property p_acp; $past(bank_a_enable_i) |-> bank_a_outputs_o == {`PCF_BANK_A_W{feedback_out_o}}; endproperty
  a_acp: assert property (p_acp) else $error("bank a off phase");
  property p_bcp; $past(bank_b_enable_i) |-> bank_b_outputs_o == {`PCF_BANK_B_W{feedback_out_o}}; endproperty
  a_bcp: assert property (p_bcp) else $error("bank b off phase");
  property p_byp; !analog_supply_strap_i |=> feedback_out_o == $past(reference_in_i); endproperty
  a_byp: assert property (p_byp) else $error("bypass not direct");
  property p_bylk; !analog_supply_strap_i |=> !lock_valid_o; endproperty
  a_bylk: assert property (p_bylk) else $error("lock in bypass");
  property p_lmin; lock_valid_o |-> run_r >= STAB_CYCLES; endproperty
  a_lmin: assert property (p_lmin) else $error("lock too early");
  property p_lgap; $rose(lock_valid_o) |-> low_r >= STAB_CYCLES; endproperty
  a_lgap: assert property (p_lgap) else $error("lock without full interval");
  property p_algn; lock_valid_o && $rose(reference_in_i) |-> ##2 feedback_out_o; endproperty
  a_algn: assert property (p_algn) else $error("output not aligned");
endmodule
`default_nettype wire

//--- tb/pcf_ref_src.sv
// Reference clock source and board feedback trace
`timescale 1ns/10ps
`default_nettype none
module pcf_ref_src (
  input  wire logic cut_i,
  input  wire logic fb_out_i,
  output var  logic ref_o,
  output wire logic fb_in_o);
  assign fb_in_o = fb_out_i & ~cut_i;  // Trace; a cut holds it low
  initial ref_o = 1'b0;
  always begin  // Fixed 160 ns period at 25% duty, edges on falling clock edges
    #20 ref_o = 1'b1;
    #40 ref_o = 1'b0;
    #100;
  end
endmodule
`default_nettype wire

//--- tb/test_pll_clock_fanout_gating.sv
// Testbench for the clock fan-out block
`timescale 1ns/10ps
`default_nettype none
module test_pll_clock_fanout_gating;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, bank_a_enable_i = 1'b1, bank_b_enable_i = 1'b1;
  logic analog_supply_strap_i = 1'b1, cut = 1'b0, reference_in_i, feedback_in_i, feedback_out_o, lock_valid_o;
  logic [4:0] bank_a_outputs_o;
  logic [3:0] bank_b_outputs_o;
  logic [7:0] ha, hb, hf;
  int err_count = 0, n_checks = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  pcf_clock_fanout #(
    .STAB_CYCLES(20)
  ) uut (
    .ref_clk_i             (ref_clk_i),
    .reset_n_i             (reset_n_i),
    .reference_in_i        (reference_in_i),
    .feedback_in_i         (feedback_in_i),
    .feedback_out_o        (feedback_out_o),
    .lock_valid_o          (lock_valid_o),
    .bank_a_enable_i       (bank_a_enable_i),
    .bank_b_enable_i       (bank_b_enable_i),
    .analog_supply_strap_i (analog_supply_strap_i),
    .bank_a_outputs_o      (bank_a_outputs_o),
    .bank_b_outputs_o      (bank_b_outputs_o)
  );
  pcf_ref_src src (.cut_i(cut), .fb_out_i(feedback_out_o), .ref_o(reference_in_i), .fb_in_o(feedback_in_i));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %0d want %0d", $time, g, e);
    end
  endtask
  task automatic meas;  // High cycles over four reference periods
    {ha, hb, hf} = '0;
    repeat (32) begin
      @(negedge ref_clk_i);
      ha += bank_a_outputs_o[0];
      hb += bank_b_outputs_o[0];
      hf += feedback_out_o;
    end
  endtask
  task automatic wait_lock(input logic e);
    for (int i = 0; i < 200 && lock_valid_o !== e; i++) @(negedge ref_clk_i);
    chk({7'h0, lock_valid_o}, {7'h0, e});
  endtask
  task automatic t_lock;
    wait_lock(1'b1);
    meas;
    chk(hf, 8'h10);
    chk(ha, 8'h10);
    $display("test end: lock");
  endtask
  task automatic t_gate;
    for (int k = 0; k < 3; k++) begin
      {bank_a_enable_i, bank_b_enable_i} = 2'b01 << k;
      repeat (2) @(negedge ref_clk_i);
      meas;
      chk(ha, bank_a_enable_i ? 8'h10 : 8'h00);
      chk(hb, bank_b_enable_i ? 8'h10 : 8'h00);
      chk(hf, 8'h10);
    end
    {bank_a_enable_i, bank_b_enable_i} = 2'b11;
    $display("test end: gate");
  endtask
  task automatic t_cut;
    cut = 1'b1;
    wait_lock(1'b0);
    cut = 1'b0;
    wait_lock(1'b1);
    analog_supply_strap_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    meas;
    chk(hf, 8'h08);
    chk({7'h0, lock_valid_o}, 8'h00);
    analog_supply_strap_i = 1'b1;
    wait_lock(1'b1);
    $display("test end: cut and bypass");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_lock;
    t_gate;
    t_cut;
    give_verdict;
  end
  initial begin  // Tests need about 300 cycles; the limit allows 5000
    #100000;
    $display("[FAIL] %0t watchdog expired", $time);
    err_count++;
    give_verdict;
  end
endmodule
bind pcf_clock_fanout pcf_checker #(
  .STAB_CYCLES(STAB_CYCLES)
) chk_i (
  .ref_clk_i             (ref_clk_i),
  .reset_n_i             (reset_n_i),
  .reference_in_i        (reference_in_i),
  .feedback_in_i         (feedback_in_i),
  .feedback_out_o        (feedback_out_o),
  .lock_valid_o          (lock_valid_o),
  .bank_a_enable_i       (bank_a_enable_i),
  .bank_b_enable_i       (bank_b_enable_i),
  .analog_supply_strap_i (analog_supply_strap_i),
  .bank_a_outputs_o      (bank_a_outputs_o),
  .bank_b_outputs_o      (bank_b_outputs_o)
);
`default_nettype wire
